// ==== hdl/host_pins_consts.vh ====
// constants for the host status and handshake pin block
`ifndef HOST_PINS_CONSTS_VH
`define HOST_PINS_CONSTS_VH

// ****************************************
// interface modes
// ****************************************
`define MODE_MEMORY       2'h0
`define MODE_IO           2'h1
`define MODE_IDE          2'h2

// ****************************************
// timing
// ****************************************
// reset processing time in ns, and its cycle count at 100 MHz
`define RESET_PROC_NS     32'h0000_03E8
`define CLK_PERIOD_NS     32'h0000_000A
`define RESET_PROC_CYC    (`RESET_PROC_NS / `CLK_PERIOD_NS)
// length of a pulse mode interrupt in cycles
`define IRQ_PULSE_CYC     8'h08
// reset held this many cycles from power-up counts as stuck
`define RESET_STUCK_CYC   16'h0400
`define CNT_W             16

`endif

// ==== hdl/pin_sync.v ====
// three flip-flop synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync (
	// clock and reset
	input  wire core_clk_i,
	input  wire rst_n_i,
	input  wire rst_val_i,
	// pin and result
	input  wire pin_i,
	output reg  level_o
);
	reg s1;
	reg s2;
	reg s3;

	// reset value comes through a constant-only reset; level_o loads later
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
		end else begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// hold the caller's level until the chain holds real pin samples,
	// otherwise the reset value of the chain shows up as a false edge
	reg [1:0] fill;
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			level_o <= 1'b1;
			fill    <= 2'h0;
		end else if (fill != 2'h3) begin
			level_o <= rst_val_i;
			fill    <= fill + 2'h1;
		end else if (s2 == s3) begin
			level_o <= s3;
		end
	end
endmodule // pin_sync

// ==== hdl/irq_shaper.v ====
// interrupt request shaper: pulse or level, active-high output
`timescale 1ns/10ps
`include "host_pins_consts.vh"
module irq_shaper (
	// clock and reset
	input  wire core_clk_i,
	input  wire rst_n_i,
	// request
	input  wire irq_req_i,
	input  wire pulse_mode_i,
	// active-high shaped request
	output reg  irq_active_o
);
	reg       req_q;
	reg [7:0] pulse_cnt;

	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_q        <= 1'b0;
			pulse_cnt    <= 8'h00;
			irq_active_o <= 1'b0;
		end else begin
			req_q <= irq_req_i;
			if (!pulse_mode_i) begin
				irq_active_o <= irq_req_i;
				pulse_cnt    <= 8'h00;
			end else if (irq_req_i && !req_q) begin
				irq_active_o <= 1'b1;
				pulse_cnt    <= `IRQ_PULSE_CYC - 8'h01;
			end else if (pulse_cnt != 8'h00) begin
				pulse_cnt <= pulse_cnt - 8'h01;
			end else begin
				irq_active_o <= 1'b0;
			end
		end
	end
endmodule // irq_shaper

// ==== hdl/host_status_pins.v ====
// status, interrupt and handshake pins of the parallel host port
//
// Overview of operation
// - io mode: acknowledge only on selected io reads
// - ide mode: request dma when data ready
// - hold dma request until acknowledge; re-request
// - memory mode: ready high, low when busy
// - ready low until reset processing completes
// - stuck reset from power-up gets ignored
// - io mode: active-low pulse or level interrupt
// - ide mode: active-high interrupt request
// - memory mode: port indicator low after init
// - io mode: low for selected 16-bit capable port
// - ide mode: low when word transfer expected
// - memory mode: pass diagnostic pin driven high
// - io mode: status change, gated by enable
// - ide mode: pass diagnostic is two-way
// - memory mode: disk active pin driven high
// - io mode: disk active held negated
// - ide mode: disk active is two-way
`timescale 1ns/10ps
`include "host_pins_consts.vh"
module host_status_pins #(
	parameter RESET_PROC_CYC = `RESET_PROC_CYC
) (
	// clock and reset
	input  wire       core_clk_i,
	input  wire       rst_n_i,
	// mode selection from the configuration logic
	input  wire [1:0] mode_i,
	input  wire       irq_pulse_mode_i,
	input  wire       status_change_en_i,
	// host pins
	input  wire       host_reset_pin_i,
	input  wire       host_io_read_strobe_n_i,
	input  wire       host_io_write_strobe_n_i,
	input  wire       dma_ack_n_i,
	// core status
	input  wire       card_busy_i,
	input  wire       io_selected_i,
	input  wire       port_16bit_i,
	input  wire       word_cycle_expected_i,
	input  wire       dma_data_ready_i,
	input  wire       irq_req_i,
	input  wire       status_changed_i,
	input  wire       diag_pass_drive_i,
	input  wire       disk_active_drive_i,
	// pin outputs
	output reg        ack_dmarq_o,
	output reg        ready_interrupt_out_o,
	output reg        iois16_n_o,
	output reg        pdiag_n_o,
	output reg        pdiag_n_oe_o,
	output reg        dasp_n_o,
	output reg        dasp_n_oe_o,
	// status to core
	output reg        host_reset_o,
	output reg        dma_dir_read_o,
	output reg        init_done_o
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	wire reset_pin_s;
	wire ior_n_s;
	wire iow_n_s;
	wire dack_n_s;

	// ide mode is the only one with an active-low reset pin
	wire ide_mode       = (mode_i == `MODE_IDE);
	// until its chain holds real samples, the reset pin reads as asserted
	wire reset_on_level = !ide_mode;

	// strobes and acknowledge idle high, so they start out negated
	pin_sync u_sync_rst (
		.core_clk_i(core_clk_i),
		.rst_n_i   (rst_n_i),
		.rst_val_i (reset_on_level),
		.pin_i     (host_reset_pin_i),
		.level_o   (reset_pin_s)
	);

	pin_sync u_sync_ior (
		.core_clk_i(core_clk_i),
		.rst_n_i   (rst_n_i),
		.rst_val_i (1'b1),
		.pin_i     (host_io_read_strobe_n_i),
		.level_o   (ior_n_s)
	);

	pin_sync u_sync_iow (
		.core_clk_i(core_clk_i),
		.rst_n_i   (rst_n_i),
		.rst_val_i (1'b1),
		.pin_i     (host_io_write_strobe_n_i),
		.level_o   (iow_n_s)
	);

	pin_sync u_sync_dack (
		.core_clk_i(core_clk_i),
		.rst_n_i   (rst_n_i),
		.rst_val_i (1'b1),
		.pin_i     (dma_ack_n_i),
		.level_o   (dack_n_s)
	);

	// reset pin is active low in ide mode, active high otherwise
	wire reset_asserted = ide_mode ? !reset_pin_s : reset_pin_s;

	// ****************************************
	// stuck-reset guard
	// ****************************************
	reg [`CNT_W-1:0] stuck_cnt;
	reg              reset_disabled;
	reg              seen_release;
	reg              sync_live;
	reg [`CNT_W-1:0] proc_cnt;

	// a reset held since power-up never releases, so stop honouring it
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stuck_cnt      <= {`CNT_W{1'b0}};
			reset_disabled <= 1'b0;
			seen_release   <= 1'b0;
			sync_live      <= 1'b0;
		end else if (!sync_live) begin
			// the first edge still sees the synchroniser's reset value
			sync_live <= 1'b1;
		end else if (!reset_asserted) begin
			seen_release   <= 1'b1;
			reset_disabled <= 1'b0;
		end else if (!seen_release && !reset_disabled) begin
			if (stuck_cnt == `RESET_STUCK_CYC - 16'h0001)
				reset_disabled <= 1'b1;
			else
				stuck_cnt <= stuck_cnt + 16'h0001;
		end
	end

	wire reset_active = reset_asserted && !reset_disabled;

	// ****************************************
	// reset processing
	// ****************************************
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			proc_cnt     <= {`CNT_W{1'b0}};
			init_done_o  <= 1'b0;
			host_reset_o <= 1'b1;
		end else begin
			host_reset_o <= reset_active;
			if (reset_active) begin
				proc_cnt    <= {`CNT_W{1'b0}};
				init_done_o <= 1'b0;
			end else if (!init_done_o) begin
				if (proc_cnt == RESET_PROC_CYC[`CNT_W-1:0] - 16'h0001)
					init_done_o <= 1'b1;
				else
					proc_cnt <= proc_cnt + 16'h0001;
			end
		end
	end

	// ****************************************
	// interrupt shaping
	// ****************************************
	wire irq_active;
	// no interrupt may reach the host before reset processing ends
	wire irq_req_gated = irq_req_i && init_done_o;
	// pulse shaping only exists in io mode
	wire irq_pulse_sel = irq_pulse_mode_i && (mode_i == `MODE_IO);

	irq_shaper u_irq (
		.core_clk_i  (core_clk_i),
		.rst_n_i     (rst_n_i),
		.irq_req_i   (irq_req_gated),
		.pulse_mode_i(irq_pulse_sel),
		.irq_active_o(irq_active)
	);

	// ****************************************
	// dma request handshake
	// ****************************************
	reg  dmarq;
	reg  dack_q;
	// requests are refused outside ide mode and before reset processing ends
	wire dma_allowed = ide_mode && init_done_o;

	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dmarq  <= 1'b0;
			dack_q <= 1'b0;
		end else begin
			// a full cycle of negated acknowledge separates two requests
			dack_q <= !dack_n_s;
			if (!dma_allowed)
				dmarq <= 1'b0;
			else if (dmarq && !dack_n_s)
				dmarq <= 1'b0;
			else if (!dmarq && dack_n_s && !dack_q && dma_data_ready_i)
				dmarq <= 1'b1;
		end
	end

	// ****************************************
	// multiword dma direction
	// ****************************************
	// the last strobe seen low sets the direction; idle strobes keep it
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dma_dir_read_o <= 1'b1;
		end else if (!ior_n_s) begin
			dma_dir_read_o <= 1'b1;
		end else if (!iow_n_s) begin
			dma_dir_read_o <= 1'b0;
		end
	end

	// ****************************************
	// pin multiplexing per mode
	// ****************************************
	reg next_ack;
	reg next_rdy;
	reg next_io16;
	reg next_pdiag;
	reg next_pdiag_oe;
	reg next_dasp;
	reg next_dasp_oe;

	always @* begin
		next_ack      = 1'b0;
		next_rdy      = 1'b0;
		next_io16     = 1'b1;
		next_pdiag    = 1'b1;
		next_pdiag_oe = 1'b1;
		next_dasp     = 1'b1;
		next_dasp_oe  = 1'b1;
		case (mode_i)
		`MODE_MEMORY: begin
			next_rdy   = init_done_o && !card_busy_i;
			next_io16  = !init_done_o;
			next_pdiag = 1'b1;
			next_dasp  = 1'b1;
		end
		`MODE_IO: begin
			next_ack   = io_selected_i && !ior_n_s;
			next_rdy   = init_done_o && !irq_active;
			next_io16  = !(io_selected_i && port_16bit_i);
			next_pdiag = !(status_change_en_i && status_changed_i);
			next_dasp  = 1'b1;
		end
		`MODE_IDE: begin
			next_ack      = dmarq;
			next_rdy      = irq_active;
			next_io16     = !word_cycle_expected_i;
			// open-drain style: drive only the low level, release otherwise
			next_pdiag    = 1'b0;
			next_pdiag_oe = diag_pass_drive_i;
			next_dasp     = 1'b0;
			next_dasp_oe  = disk_active_drive_i;
		end
		default: begin
			next_pdiag_oe = 1'b0;
			next_dasp_oe  = 1'b0;
		end
		endcase
	end

	// ****************************************
	// pin output registers
	// ****************************************
	// every pin comes from a flop, so a mode change shows one cycle late
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_dmarq_o           <= 1'b0;
			ready_interrupt_out_o <= 1'b0;
			iois16_n_o            <= 1'b1;
			pdiag_n_o             <= 1'b1;
			pdiag_n_oe_o          <= 1'b0;
			dasp_n_o              <= 1'b1;
			dasp_n_oe_o           <= 1'b0;
		end else begin
			ack_dmarq_o           <= next_ack;
			ready_interrupt_out_o <= next_rdy;
			iois16_n_o            <= next_io16;
			pdiag_n_o             <= next_pdiag;
			pdiag_n_oe_o          <= next_pdiag_oe;
			dasp_n_o              <= next_dasp;
			dasp_n_oe_o           <= next_dasp_oe;
		end
	end
endmodule // host_status_pins

// ==== verif/host_status_pins_checker.sv ====
// concurrent checks on the host status pin block
`timescale 1ns/10ps
`include "host_pins_consts.vh"
module host_status_pins_checker #(
	parameter RESET_PROC_CYC = 100
) (
	// clock and reset
	input wire       core_clk_i,
	input wire       rst_n_i,
	// inputs
	input wire [1:0] mode_i,
	input wire       irq_pulse_mode_i,
	input wire       host_reset_pin_i,
	input wire       dma_ack_n_i,
	input wire       card_busy_i,
	input wire       io_selected_i,
	input wire       port_16bit_i,
	input wire       dma_data_ready_i,
	input wire       irq_req_i,
	// outputs
	input wire       ack_dmarq_o,
	input wire       ready_interrupt_out_o,
	input wire       iois16_n_o,
	input wire       init_done_o
);
	localparam STUCK_LIM = 1024 + RESET_PROC_CYC + 40;
	reg [1:0]  mode_q;
	reg [11:0] stuck_cnt;
	// modes count only once steady for a cycle, since outputs are registered
	wire m_mem = mode_i == mode_q && mode_i == `MODE_MEMORY;
	wire m_io = mode_i == mode_q && mode_i == `MODE_IO;
	wire m_ide = mode_i == mode_q && mode_i == `MODE_IDE;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_q <= 2'h3;
			stuck_cnt <= 12'h000;
		end else begin
			mode_q <= mode_i;
			// once released, a later high pin is a real reset
			if (!host_reset_pin_i)
				stuck_cnt <= 12'h800;
			else if (stuck_cnt < STUCK_LIM)
				stuck_cnt <= stuck_cnt + 12'h001;
		end
	end
	property p_io_ack;
		m_io && ack_dmarq_o |-> $past(io_selected_i);
	endproperty
	a_io_ack: assert property (p_io_ack) else $error("io ack unselected");
	property p_dmarq_rise;
		m_ide && $rose(ack_dmarq_o) |-> $past(dma_data_ready_i, 2) && init_done_o;
	endproperty
	a_dmarq_rise: assert property (p_dmarq_rise) else $error("dma request uncaused");
	property p_dmarq_drop;
		m_ide && $fell(dma_ack_n_i) |-> ##[1:6] !ack_dmarq_o;
	endproperty
	a_dmarq_drop: assert property (p_dmarq_drop) else $error("dma request kept");
	property p_mem_ready;
		m_mem && init_done_o && $past(init_done_o)
			|-> !iois16_n_o && ready_interrupt_out_o == !$past(card_busy_i);
	endproperty
	a_mem_ready: assert property (p_mem_ready) else $error("memory ready wrong");
	property p_busy_low;
		m_mem && !init_done_o && !$past(init_done_o) |-> !ready_interrupt_out_o;
	endproperty
	a_busy_low: assert property (p_busy_low) else $error("ready before init");
	property p_stuck;
		stuck_cnt == STUCK_LIM |-> init_done_o;
	endproperty
	a_stuck: assert property (p_stuck) else $error("stuck reset kept busy");
	property p_irq_pulse;
		m_io && irq_pulse_mode_i && init_done_o && $rose(irq_req_i)
			|-> ##[1:2] !ready_interrupt_out_o [*8] ##1 ready_interrupt_out_o;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("irq pulse length");
	property p_io_port;
		m_io |-> iois16_n_o == !($past(io_selected_i) && $past(port_16bit_i));
	endproperty
	a_io_port: assert property (p_io_port) else $error("io port width wrong");
endmodule // host_status_pins_checker
bind host_status_pins host_status_pins_checker #(.RESET_PROC_CYC(RESET_PROC_CYC)) chk_u (
	.core_clk_i, .rst_n_i, .mode_i, .irq_pulse_mode_i, .host_reset_pin_i, .dma_ack_n_i,
	.card_busy_i, .io_selected_i, .port_16bit_i, .dma_data_ready_i, .irq_req_i, .ack_dmarq_o,
	.ready_interrupt_out_o, .iois16_n_o, .init_done_o);

// ==== verif/host_dma_model.sv ====
// host side model: answers dma requests and drives the io strobes
`timescale 1ns/10ps
module host_dma_model (
	// clock and reset
	input  wire       core_clk_i,
	input  wire       rst_n_i,
	// bench control
	input  wire       en_i,
	input  wire       busy_i,
	input  wire       io_rd_i,
	input  wire       dir_rd_i,
	input  wire [3:0] lag_i,
	// pins
	input  wire       dmarq_i,
	output reg        dma_ack_n_o = 1'b1,
	output wire       rd_strobe_n_o,
	output wire       wr_strobe_n_o
);
	reg [3:0] wait_cnt;
	assign rd_strobe_n_o = !(io_rd_i || (!dma_ack_n_o && dir_rd_i));
	assign wr_strobe_n_o = !(!dma_ack_n_o && !dir_rd_i);
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_cnt <= 4'h0;
			dma_ack_n_o <= 1'b1;
		end else if (!dma_ack_n_o) begin
			if (!dmarq_i) begin
				dma_ack_n_o <= 1'b1;
				wait_cnt <= 4'h0;
			end
		end else if (en_i && dmarq_i && !busy_i) begin
			if (wait_cnt == lag_i)
				dma_ack_n_o <= 1'b0;
			else
				wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule // host_dma_model

// ==== verif/host_status_pins_tb_top.sv ====
// self-checking bench for the host status pin block
`timescale 1ns/10ps
`include "host_pins_consts.vh"
module host_status_pins_tb_top;
	reg [1:0] mode_i;
	reg       core_clk_i, rst_n_i, irq_pulse_mode_i, status_change_en_i, host_reset_pin_i;
	reg       card_busy_i, io_selected_i, port_16bit_i, word_cycle_expected_i, dma_data_ready_i;
	reg       irq_req_i, status_changed_i, diag_pass_drive_i, disk_active_drive_i, io_rd, dir_rd;
	reg [3:0] lag;
	wire      host_io_read_strobe_n_i, host_io_write_strobe_n_i, dma_ack_n_i, ack_dmarq_o;
	wire      ready_interrupt_out_o, iois16_n_o, pdiag_n_o, pdiag_n_oe_o, dasp_n_o, dasp_n_oe_o;
	wire      dma_dir_read_o, init_done_o, host_reset_o;
	int       fail_count, samples_checked, cyc;
	// both lines have pull-ups, so released reads high
	wire      pd_line = pdiag_n_oe_o ? pdiag_n_o : 1'b1;
	wire      da_line = dasp_n_oe_o ? dasp_n_o : 1'b1;
	host_status_pins #(.RESET_PROC_CYC(20)) dut_u (.core_clk_i, .rst_n_i, .mode_i,
		.irq_pulse_mode_i, .status_change_en_i, .host_reset_pin_i, .host_io_read_strobe_n_i,
		.host_io_write_strobe_n_i, .dma_ack_n_i, .card_busy_i, .io_selected_i, .port_16bit_i,
		.word_cycle_expected_i, .dma_data_ready_i, .irq_req_i, .status_changed_i,
		.diag_pass_drive_i, .disk_active_drive_i, .ack_dmarq_o, .ready_interrupt_out_o,
		.iois16_n_o, .pdiag_n_o, .pdiag_n_oe_o, .dasp_n_o, .dasp_n_oe_o, .host_reset_o,
		.dma_dir_read_o, .init_done_o);
	host_dma_model host_u (.core_clk_i, .rst_n_i, .en_i(mode_i == `MODE_IDE),
		.busy_i(!init_done_o), .io_rd_i(io_rd), .dir_rd_i(dir_rd), .lag_i(lag),
		.dmarq_i(ack_dmarq_o), .dma_ack_n_o(dma_ack_n_i),
		.rd_strobe_n_o(host_io_read_strobe_n_i), .wr_strobe_n_o(host_io_write_strobe_n_i));
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			wrap_up;
		end
	end
	task chk(input string n, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %b seen %b", n, e, g);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task wait_init;
		int i;
		for (i = 0; i < 1500 && init_done_o !== 1'b1; i++)
			tick(1);
		chk("init_done", 1'b1, init_done_o);
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task t_mem;
		chk("ready_busy", 1'b0, ready_interrupt_out_o);
		wait_init;
		tick(2);
		chk("mem_host_reset", 1'b0, host_reset_o);
		chk("mem_port", 1'b0, iois16_n_o);
		chk("mem_diag", 1'b1, pd_line);
		chk("mem_dasp", 1'b1, da_line);
		chk("mem_ready", 1'b1, ready_interrupt_out_o);
		@(posedge core_clk_i) card_busy_i <= 1'b1;
		tick(2);
		chk("mem_ready", 1'b0, ready_interrupt_out_o);
	endtask
	task t_io;
		int v;
		@(posedge core_clk_i) mode_i <= `MODE_IO;
		for (v = 1; v >= 0; v--) begin
			@(posedge core_clk_i) begin
				{io_selected_i, io_rd, port_16bit_i, status_changed_i} <= {4{v[0]}};
				status_change_en_i <= 1'b1;
			end
			tick(8);
			chk("io_ack", v[0], ack_dmarq_o);
			chk("io_port", !v[0], iois16_n_o);
			chk("io_change", !v[0], pd_line);
			chk("io_dasp", 1'b1, da_line);
		end
		for (v = 0; v < 2; v++) begin
			@(posedge core_clk_i) begin
				irq_pulse_mode_i <= v[0];
				irq_req_i <= 1'b1;
			end
			tick(3);
			chk("io_irq", 1'b0, ready_interrupt_out_o);
			tick(10);
			chk("io_irq_late", v[0], ready_interrupt_out_o);
			@(posedge core_clk_i) irq_req_i <= 1'b0;
			tick(3);
			chk("io_irq_idle", 1'b1, ready_interrupt_out_o);
		end
	endtask
	task t_ide;
		int k, i;
		@(posedge core_clk_i) {mode_i, host_reset_pin_i} <= {`MODE_IDE, 1'b1};
		tick(10);
		wait_init;
		for (k = 0; k < 2; k++) begin
			@(posedge core_clk_i) {dir_rd, lag, dma_data_ready_i} <= {k[0], 1'b0, k[0], 2'h2, 1'b1};
			for (i = 0; i < 40 && dma_ack_n_i !== 1'b0; i++)
				tick(1);
			chk("dmarq_held", 1'b1, ack_dmarq_o);
			tick(8);
			chk("dmarq_drop", 1'b0, ack_dmarq_o);
			chk("dma_dir", k[0], dma_dir_read_o);
			tick(6);
			chk("dmarq_again", 1'b1, ack_dmarq_o);
			@(posedge core_clk_i) dma_data_ready_i <= 1'b0;
			tick(30);
			chk("dmarq_done", 1'b0, ack_dmarq_o);
		end
		for (k = 1; k >= 0; k--) begin
			@(posedge core_clk_i) begin
				{irq_req_i, word_cycle_expected_i} <= {2{k[0]}};
				{diag_pass_drive_i, disk_active_drive_i} <= {2{k[0]}};
			end
			tick(3);
			chk("ide_irq", k[0], ready_interrupt_out_o);
			chk("ide_word", !k[0], iois16_n_o);
			chk("ide_diag", !k[0], pd_line);
			chk("ide_dasp", !k[0], da_line);
		end
		@(posedge core_clk_i) mode_i <= 2'h3;
		tick(3);
		chk("idle_diag_oe", 1'b0, pdiag_n_oe_o);
		chk("idle_dasp_oe", 1'b0, dasp_n_oe_o);
		chk("idle_ack", 1'b0, ack_dmarq_o);
	endtask
	task t_stuck;
		@(posedge core_clk_i) {rst_n_i, mode_i} <= {1'b0, `MODE_MEMORY};
		tick(8);
		@(posedge core_clk_i) rst_n_i <= 1'b1;
		tick(600);
		chk("stuck_busy", 1'b0, init_done_o);
		chk("stuck_reset", 1'b1, host_reset_o);
		wait_init;
		chk("stuck_ignored", 1'b0, host_reset_o);
	endtask
	initial begin
		{mode_i, rst_n_i, irq_pulse_mode_i, status_change_en_i, host_reset_pin_i, card_busy_i,
			io_selected_i, port_16bit_i, word_cycle_expected_i, dma_data_ready_i, irq_req_i,
			status_changed_i, diag_pass_drive_i, disk_active_drive_i, io_rd, dir_rd, lag} = '0;
		tick(8);
		@(posedge core_clk_i) rst_n_i <= 1'b1;
		tick(1);
		t_mem;
		t_io;
		t_ide;
		t_stuck;
		wrap_up;
	end
endmodule // host_status_pins_tb_top
